// [logic/tpp_pkg.sv]
// token parallel port: shared codes, roles, pin levels and strobe timing.
// assumes a single 40 MHz system clock on both ends of the link.
package tpp_pkg;

  // ----------------------------------------
  // roles
  // ----------------------------------------
  typedef enum logic [2:0] {
    ROLE_MASTER  = 3'b001,
    ROLE_SLAVE_A = 3'b010,
    ROLE_SLAVE_B = 3'b100
  } tpp_role_e;

  // ----------------------------------------
  // command codes and framing
  // ----------------------------------------
  localparam logic [7:0] CMD_PASS_TOKEN = 8'h00;
  localparam logic [7:0] CMD_WRITE_DATA = 8'h01;
  localparam logic [7:0] REQ_A_CODE = 8'h5A;
  localparam logic [7:0] REQ_A_ACK = 8'h07;
  localparam logic [7:0] END_OF_MESSAGE = 8'h00;
  localparam logic [7:0] SLAVE_MSG_LEN = 8'h01;

  // ----------------------------------------
  // register select and control register layout
  // ----------------------------------------
  localparam logic REG_SEL_DATA = 1'b0;
  localparam logic REG_SEL_CTRL = 1'b1;
  localparam int DATA_BIT_ZERO = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BUS_IDLE = 8'hFF;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS = 25;
  localparam int STROBE_LOW_NS = 100;
  localparam int STROBE_HOLD_NS = 75;
  localparam int SETTLE_NS = 250;
  localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_HOLD_CYC = (STROBE_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

endpackage

// [logic/tpp_link_if.sv]
// token parallel port link: eight data lines, strobe, direction, register
// select and the slave busy line. resolves the shared data wires from the
// two drive enables; an undriven bus reads as all ones (pull-ups).
`timescale 1ns/1ps
`default_nettype none
interface tpp_link_if;
  logic [7:0] m_data;
  logic m_data_oe_n;
  logic [7:0] s_data;
  logic s_data_oe_n;
  logic [7:0] bus;
  logic strobe_n;
  logic rnw;
  logic reg_select;
  logic slave_busy_flag;

  assign bus = !m_data_oe_n ? m_data : (!s_data_oe_n ? s_data : tpp_pkg::BUS_IDLE);

  modport master_end (
    output m_data, m_data_oe_n, strobe_n, rnw, reg_select,
    input bus, slave_busy_flag
  );
  modport slave_end (
    output s_data, s_data_oe_n, slave_busy_flag,
    input bus, strobe_n, rnw, reg_select
  );
endinterface
`default_nettype wire

// [logic/tpp_fifo.sv]
// small synchronous fifo with valid/ready on both sides.
// assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module tpp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] used;
  logic push;
  logic pop;

  assign used = wr_ptr - rd_ptr;
  assign in_ready_out = (used != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid_out = (used != '0);
  assign out_data_out = mem[rd_ptr[AW-1:0]];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // storage needs no reset: nothing reads an entry before it is written
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end
endmodule
`default_nettype wire

// [logic/tpp_master.sv]
// token parallel port, master end: drives strobe, direction and register
// select, polls the slave busy state and runs the command framing.
// assumes the partner slave answers a strobe within the settle time.
`timescale 1ns/1ps
`default_nettype none
module tpp_master (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // link
  tpp_link_if.master_end link,
  // configuration
  input wire tpp_pkg::tpp_role_e partner_role_in,
  // transmit message
  input wire logic tx_start_in,
  input wire logic [7:0] tx_len_in,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out,
  // receive stream
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  // synchronisation
  input wire logic resync_req_in,
  output logic synced_out
);
  import tpp_pkg::*;

  typedef enum logic [2:0] {
    PH_SETTLE = 3'b001,
    PH_LOW = 3'b010,
    PH_HOLD = 3'b100
  } tpp_phase_e;

  typedef enum logic [7:0] {
    W_CMD = 8'h01, W_LEN = 8'h02, W_DATA = 8'h04, W_EOM = 8'h08,
    R_CMD = 8'h10, R_LEN = 8'h20, R_DATA = 8'h40, R_EOM = 8'h80
  } tpp_mproto_e;

  tpp_phase_e phase;
  tpp_mproto_e pst;
  logic [3:0] tmr;
  logic poll;
  logic step;
  logic [7:0] cap;
  logic [7:0] cnt;
  logic resync_pend;
  logic reading;
  logic go;
  logic [7:0] next_wbyte;

  assign reading = pst inside {R_CMD, R_LEN, R_DATA, R_EOM};
  assign go = !(pst == W_DATA && !tx_valid_in);
  assign tx_ready_out = step && pst == W_DATA;

  always_comb begin
    unique case (pst)
      W_CMD: next_wbyte = resync_pend ? REQ_A_CODE :
          (tx_start_in ? CMD_WRITE_DATA : CMD_PASS_TOKEN);
      W_LEN: next_wbyte = tx_len_in;
      W_DATA: next_wbyte = tx_data_in;
      default: next_wbyte = END_OF_MESSAGE;
    endcase
  end

  // ----------------------------------------
  // strobe engine
  // ----------------------------------------
  // settle after every strobe but a clear control poll whose next access can go: the busy line is only trusted once the
  // slave has had time to synchronise the strobe and react to it
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      phase <= PH_SETTLE;
      tmr <= 4'(SETTLE_CYC - 1);
      poll <= 1'b0;
      step <= 1'b0;
      cap <= 8'h00;
      link.strobe_n <= 1'b1;
      link.rnw <= 1'b1;
      link.reg_select <= REG_SEL_DATA;
      link.m_data <= 8'h00;
      link.m_data_oe_n <= 1'b1;
    end else begin
      step <= 1'b0;
      unique case (phase)
        PH_SETTLE: begin
          if (tmr != 4'h0) begin
            tmr <= tmr - 4'h1;
          end else if (partner_role_in == ROLE_SLAVE_B) begin
            phase <= PH_LOW;
            tmr <= 4'(STROBE_LOW_CYC - 1);
            poll <= 1'b1;
            link.strobe_n <= 1'b0;
            link.rnw <= 1'b1;
            link.reg_select <= REG_SEL_CTRL;
          end else if (!link.slave_busy_flag && go) begin
            phase <= PH_LOW;
            tmr <= 4'(STROBE_LOW_CYC - 1);
            poll <= 1'b0;
            link.strobe_n <= 1'b0;
            link.rnw <= reading;
            link.reg_select <= REG_SEL_DATA;
            link.m_data <= next_wbyte;
            link.m_data_oe_n <= reading;
          end
        end
        PH_LOW: begin
          if (tmr != 4'h0) begin
            tmr <= tmr - 4'h1;
          end else begin
            phase <= PH_HOLD;
            tmr <= 4'(STROBE_HOLD_CYC - 1);
            link.strobe_n <= 1'b1;
            cap <= link.bus;
          end
        end
        PH_HOLD: begin
          if (tmr != 4'h0) begin
            tmr <= tmr - 4'h1;
          end else begin
            link.m_data_oe_n <= 1'b1;
            link.reg_select <= REG_SEL_DATA;
            if (poll && !cap[DATA_BIT_ZERO] && go) begin
              phase <= PH_LOW;
              tmr <= 4'(STROBE_LOW_CYC - 1);
              poll <= 1'b0;
              link.strobe_n <= 1'b0;
              link.rnw <= reading;
              link.m_data <= next_wbyte;
              link.m_data_oe_n <= reading;
            end else begin
              phase <= PH_SETTLE;
              tmr <= 4'(SETTLE_CYC - 1);
              step <= !poll;
            end
          end
        end
        default: begin
          phase <= PH_SETTLE;
          tmr <= 4'(SETTLE_CYC - 1);
        end
      endcase
    end
  end

  // ----------------------------------------
  // command framing
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      resync_pend <= 1'b1;
    end else if (resync_req_in) begin
      resync_pend <= 1'b1;
    end else if (step && pst == W_CMD && link.m_data == REQ_A_CODE) begin
      resync_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pst <= W_CMD;
      cnt <= 8'h00;
      synced_out <= 1'b0;
      rx_valid_out <= 1'b0;
      rx_data_out <= 8'h00;
    end else begin
      rx_valid_out <= 1'b0;
      if (step) begin
        unique case (pst)
          W_CMD: begin
            if (link.m_data == REQ_A_CODE) begin
              synced_out <= 1'b0;
            end
            pst <= (link.m_data == CMD_WRITE_DATA) ? W_LEN : W_EOM;
          end
          W_LEN: begin
            cnt <= link.m_data;
            pst <= (link.m_data == 8'h00) ? W_EOM : W_DATA;
          end
          W_DATA: begin
            cnt <= cnt - 8'h01;
            pst <= (cnt == 8'h01) ? W_EOM : W_DATA;
          end
          W_EOM: pst <= R_CMD;
          R_CMD: begin
            if (cap == REQ_A_ACK) begin
              synced_out <= 1'b1;
            end
            pst <= (cap == CMD_WRITE_DATA) ? R_LEN : R_EOM;
          end
          R_LEN: begin
            cnt <= cap;
            pst <= (cap == 8'h00) ? R_EOM : R_DATA;
          end
          R_DATA: begin
            rx_valid_out <= 1'b1;
            rx_data_out <= cap;
            cnt <= cnt - 8'h01;
            pst <= (cnt == 8'h01) ? R_EOM : R_DATA;
          end
          R_EOM: pst <= W_CMD;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// [logic/tpp_slave.sv]
// token parallel port, slave end (slave A or slave B role): synchronises
// the strobe, owns the busy line, parses master commands into a receive
// fifo and answers with its own commands while it holds the write token.
// assumes the master holds data, direction and select stable for a few
// clocks after raising the strobe.
//
// Notes on behaviour
// - eight data lines, three controls, three roles
// - master role steers the whole handshake
// - only master strobes; one pulse, one byte
// - strobe treated as asynchronous here
// - master direction line sets read or write
// - slave alone drives busy; high means slave
// - busy may change before strobe returns high
// - slave B select picks data or control
// - busy bit sits on data bit zero
// - slave B master reads control to poll
// - single write token; only holder writes
// - one command per token, then token passes
// - end byte content never interpreted
// - count equals data bytes, end excluded
// - bytes captured on strobe rising edge
// - master access raises busy, slave lowers
// - control read leaves busy unchanged
// - master resyncs after reset; slave waits
`timescale 1ns/1ps
`default_nettype none
module tpp_slave #(
  parameter int FIFO_WIDTH = 8,
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // link
  tpp_link_if.slave_end link,
  // configuration
  input wire tpp_pkg::tpp_role_e role_in,
  // receive stream
  output logic rx_valid_out,
  output logic [FIFO_WIDTH-1:0] rx_data_out,
  input wire logic rx_ready_in,
  // transmit byte
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out,
  // status
  output logic synced_out,
  output logic busy_out
);
  import tpp_pkg::*;

  typedef enum logic [9:0] {
    ST_UNSYNC = 10'h001,
    ST_M_CMD = 10'h002,
    ST_M_LEN = 10'h004,
    ST_M_DATA = 10'h008,
    ST_M_EOM = 10'h010,
    ST_T_LEN = 10'h020,
    ST_T_DATA = 10'h040,
    ST_T_EOM = 10'h080,
    ST_T_GIVE = 10'h100,
    ST_T_CMD = 10'h200
  } tpp_sstate_e;

  tpp_sstate_e state;
  logic strobe_meta;
  logic strobe_sync;
  logic strobe_prev;
  logic acc_rise;
  logic sel_ctrl;
  logic master_tok;
  logic master_wr;
  logic master_rd;
  logic busy;
  logic [7:0] rx_byte;
  logic [7:0] tx_reg;
  logic [7:0] cnt;
  logic ack_pend;
  logic fifo_in_ready;
  logic fifo_push;
  logic slave_act;

  // ----------------------------------------
  // strobe synchroniser
  // ----------------------------------------
  // the strobe comes from another clock; only the second and third stages are looked at
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      strobe_meta <= 1'b1;
      strobe_sync <= 1'b1;
      strobe_prev <= 1'b1;
    end else begin
      strobe_meta <= link.strobe_n;
      strobe_sync <= strobe_meta;
      strobe_prev <= strobe_sync;
    end
  end

  assign acc_rise = strobe_sync & ~strobe_prev;
  assign sel_ctrl = (role_in == ROLE_SLAVE_B) && (link.reg_select == REG_SEL_CTRL);
  assign master_tok = state inside {ST_UNSYNC, ST_M_CMD, ST_M_LEN, ST_M_DATA, ST_M_EOM};
  // accesses against the token direction are dropped and leave busy alone
  assign master_wr = acc_rise && !link.rnw && !sel_ctrl && master_tok;
  assign master_rd = acc_rise && link.rnw && !sel_ctrl && !master_tok;
  assign slave_act = busy && (state != ST_M_DATA || fifo_in_ready);
  assign fifo_push = slave_act && state == ST_M_DATA;
  assign tx_ready_out = slave_act && state == ST_T_DATA;
  assign busy_out = busy;

  // ----------------------------------------
  // pins
  // ----------------------------------------
  // drivers follow the direction line while the strobe is low, so read
  // data is on the bus before the rising edge the master captures on
  assign link.s_data_oe_n = !(link.rnw && !link.strobe_n);
  assign link.s_data = sel_ctrl ? {CTRL_RESET[7:1], busy} : tx_reg;
  // slave B presents no busy pin; the line stays low there
  assign link.slave_busy_flag = (role_in == ROLE_SLAVE_A) ? busy : 1'b0;

  // ----------------------------------------
  // busy line and byte capture
  // ----------------------------------------
  // a master access sets busy ahead of any slave action in the same cycle
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      busy <= 1'b0;
      rx_byte <= 8'h00;
    end else if (master_wr || master_rd) begin
      busy <= 1'b1;
      if (master_wr) begin
        rx_byte <= link.bus;
      end
    end else if (slave_act && state != ST_M_EOM) begin
      // the end byte keeps busy up one more cycle, until the command is loaded
      busy <= 1'b0;
    end
  end

  // ----------------------------------------
  // command framing
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= ST_UNSYNC;
      tx_reg <= 8'h00;
      cnt <= 8'h00;
      ack_pend <= 1'b0;
      synced_out <= 1'b0;
    end else if (slave_act && !(master_wr || master_rd)) begin
      unique case (state)
        ST_UNSYNC: begin
          if (rx_byte == REQ_A_CODE) begin
            ack_pend <= 1'b1;
            state <= ST_M_EOM;
          end
        end
        ST_M_CMD: begin
          if (rx_byte == CMD_WRITE_DATA) begin
            state <= ST_M_LEN;
          end else begin
            if (rx_byte == REQ_A_CODE) begin
              ack_pend <= 1'b1;
              synced_out <= 1'b0;
            end
            state <= ST_M_EOM;
          end
        end
        ST_M_LEN: begin
          cnt <= rx_byte;
          state <= (rx_byte == 8'h00) ? ST_M_EOM : ST_M_DATA;
        end
        ST_M_DATA: begin
          cnt <= cnt - 8'h01;
          state <= (cnt == 8'h01) ? ST_M_EOM : ST_M_DATA;
        end
        ST_M_EOM: begin
          // end byte content is ignored; it only hands the token over
          state <= ST_T_CMD;
        end
        ST_T_CMD: begin
          if (ack_pend) begin
            tx_reg <= REQ_A_ACK;
            ack_pend <= 1'b0;
            synced_out <= 1'b1;
            state <= ST_T_EOM;
          end else if (tx_valid_in) begin
            tx_reg <= CMD_WRITE_DATA;
            state <= ST_T_LEN;
          end else begin
            tx_reg <= CMD_PASS_TOKEN;
            state <= ST_T_EOM;
          end
        end
        ST_T_LEN: begin
          tx_reg <= SLAVE_MSG_LEN;
          state <= ST_T_DATA;
        end
        ST_T_DATA: begin
          tx_reg <= tx_data_in;
          state <= ST_T_EOM;
        end
        ST_T_EOM: begin
          tx_reg <= END_OF_MESSAGE;
          state <= ST_T_GIVE;
        end
        ST_T_GIVE: begin
          state <= ST_M_CMD;
        end
      endcase
    end
  end

  // the end byte of the master arrives with busy set; the slave then
  // loads its command in the next action, so the end byte itself clears
  // busy only when the command byte is ready on the bus

  // ----------------------------------------
  // receive buffer
  // ----------------------------------------
  // a full fifo holds busy high, which stalls the master's next byte
  tpp_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .in_valid_in(fifo_push),
    .in_data_in(FIFO_WIDTH'(rx_byte)),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(rx_valid_out),
    .out_data_out(rx_data_out),
    .out_ready_in(rx_ready_in)
  );
endmodule
`default_nettype wire

// [test/tpp_link_assertions.sv]
// link checker: timing and ownership properties of the port wires.
// assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module tpp_link_checker (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // link wires
  input wire logic m_data_oe_n,
  input wire logic s_data_oe_n,
  input wire logic strobe_n,
  input wire logic rnw,
  input wire logic reg_select,
  input wire logic slave_busy_flag
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);

  // ------
  // ownership
  // ------
  a_no_bus_fight: assert property (m_data_oe_n || s_data_oe_n)
    else $error("both ends drive the bus");
  a_slave_drive_dir: assert property (!s_data_oe_n |-> !strobe_n && rnw)
    else $error("slave drives outside a read");
  a_master_drive_dir: assert property (!m_data_oe_n |-> !rnw)
    else $error("master drives during a read");
  a_busy_slave_turn: assert property ($fell(strobe_n) |-> !slave_busy_flag)
    else $error("strobe while slave busy");

  // ------
  // strobe timing
  // ------
  a_strobe_low_len: assert property ($fell(strobe_n) |-> !strobe_n [*4] ##1 strobe_n)
    else $error("strobe low width wrong");
  a_strobe_gap: assert property ($rose(strobe_n) && !reg_select |-> strobe_n [*8])
    else $error("strobe gap too short");
  // a clear control poll may go straight on to the access after the hold
  a_poll_gap: assert property ($rose(strobe_n) && reg_select |-> strobe_n [*3])
    else $error("control poll hold too short");
  a_hold_stable: assert property (
    $rose(strobe_n) |-> ($stable(rnw) && $stable(reg_select)) [*3])
    else $error("direction or select moved in hold");
  a_oe_release: assert property (
    $rose(strobe_n) && !m_data_oe_n |-> !m_data_oe_n [*3] ##1 m_data_oe_n)
    else $error("master data hold wrong");
  // busy is set only through the synchronised strobe edge
  a_busy_after_strobe: assert property (
    $rose(slave_busy_flag) |-> $past(strobe_n, 3) && !$past(strobe_n, 4))
    else $error("busy rise not tied to strobe edge");
endmodule
`default_nettype wire

// [test/tb.sv]
// bench: master and slave ends face each other over one link.
// assumes the design files and the link checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tpp_pkg::*;
  localparam int LIM = 4000;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  tpp_role_e m_role = ROLE_SLAVE_A;
  tpp_role_e s_role = ROLE_SLAVE_A;
  logic m_start = 1'b0;
  logic [7:0] m_len = 8'h00;
  logic m_tx_valid = 1'b0;
  logic [7:0] m_tx_data = 8'h00;
  logic m_resync = 1'b0;
  logic s_rx_ready = 1'b1;
  logic s_tx_valid = 1'b0;
  logic [7:0] s_tx_data = 8'h00;
  logic m_tx_ready, m_rx_valid, m_synced, s_rx_valid, s_tx_ready, s_synced, s_busy;
  logic [7:0] m_rx_data, s_rx_data, held, last_ctrl;
  logic held_rnw, held_sel;
  logic pending = 1'b0;
  logic [7:0] rxq[$], mrq[$], wq[$], rq[$];
  int num_errors = 0;
  int compares = 0;
  int txk = 0;
  int n;

  always #12.5 clk_sys_in = ~clk_sys_in;

  tpp_link_if link();
  tpp_master u_tpp_master (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .link(link.master_end), .partner_role_in(m_role), .tx_start_in(m_start),
    .tx_len_in(m_len), .tx_valid_in(m_tx_valid), .tx_data_in(m_tx_data),
    .tx_ready_out(m_tx_ready), .rx_valid_out(m_rx_valid), .rx_data_out(m_rx_data),
    .resync_req_in(m_resync), .synced_out(m_synced));
  tpp_slave #(.FIFO_WIDTH(8), .FIFO_DEPTH(8)) u_tpp_slave (.clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in), .link(link.slave_end), .role_in(s_role),
    .rx_valid_out(s_rx_valid), .rx_data_out(s_rx_data), .rx_ready_in(s_rx_ready),
    .tx_valid_in(s_tx_valid), .tx_data_in(s_tx_data), .tx_ready_out(s_tx_ready),
    .synced_out(s_synced), .busy_out(s_busy));
  tpp_link_checker u_tpp_link_checker (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .m_data_oe_n(link.m_data_oe_n), .s_data_oe_n(link.s_data_oe_n),
    .strobe_n(link.strobe_n), .rnw(link.rnw), .reg_select(link.reg_select),
    .slave_busy_flag(link.slave_busy_flag));

  // ------
  // monitors
  // ------
  // next master byte follows each accepted one
  always @(posedge clk_sys_in) begin
    if (s_rx_valid && s_rx_ready) rxq.push_back(s_rx_data);
    if (m_rx_valid) mrq.push_back(m_rx_data);
    if (m_tx_ready) begin
      txk <= txk + 1;
      m_tx_data <= m_tx_data + 8'h01;
    end
  end

  // bus taken while strobe low: the slave lets go as the strobe rises
  always @(negedge clk_sys_in) begin
    if (!link.strobe_n) begin
      held <= link.bus;
      held_rnw <= link.rnw;
      held_sel <= link.reg_select;
      pending <= 1'b1;
    end else if (pending) begin
      pending <= 1'b0;
      if (held_sel) last_ctrl <= held;
      else if (held_rnw) rq.push_back(held);
      else wq.push_back(held);
    end
  end

  // ------
  // helpers
  // ------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic guard();
    if (n >= LIM) begin
      check(32'h0, 32'h1);
      complete_run();
    end
  endtask

  function automatic bit has_byte(input logic [7:0] q[$], input logic [7:0] v);
    foreach (q[i]) if (q[i] === v) return 1'b1;
    return 1'b0;
  endfunction

  task automatic check_frame(input logic [7:0] q[$], input logic [7:0] len,
    input logic [7:0] base);
    int i;
    i = 0;
    while (i < q.size() && q[i] !== CMD_WRITE_DATA) i++;
    check(q[i+1], len);
    for (int k = 0; k < len; k++) check(q[i+2+k], base + k);
    check(q.size() > i + len + 2, 1'b1);
  endtask

  task automatic do_reset(input tpp_role_e role);
    @(posedge clk_sys_in);
    resetn_in <= 1'b0;
    m_role <= role;
    s_role <= role;
    repeat (20) @(posedge clk_sys_in);
    wq.delete();
    rq.delete();
    resetn_in <= 1'b1;
  endtask

  task automatic send(input logic [7:0] len, input logic [7:0] base);
    @(posedge clk_sys_in);
    wq.delete();
    rxq.delete();
    txk <= 0;
    m_len <= len;
    m_tx_data <= base;
    m_tx_valid <= 1'b1;
    m_start <= 1'b1;
  endtask

  task automatic end_send(input logic [7:0] len, input logic [7:0] base);
    for (n = 0; n < LIM && rxq.size() < len; n++) begin
      @(posedge clk_sys_in);
      if (txk == len) begin
        m_start <= 1'b0;
        m_tx_valid <= 1'b0;
      end
    end
    guard();
    repeat (40) @(posedge clk_sys_in);
    check_frame(wq, len, base);
    foreach (rxq[k]) check(rxq[k], base + k);
  endtask

  // ------
  // scenarios
  // ------
  task automatic sc_sync(input tpp_role_e role);
    do_reset(role);
    @(negedge clk_sys_in);
    check(s_synced, 1'b0);
    for (n = 0; n < LIM && !(m_synced && s_synced && rq.size() > 0); n++)
      @(posedge clk_sys_in);
    guard();
    check(wq[0], REQ_A_CODE);
    check(rq[0], REQ_A_ACK);
  endtask

  task automatic sc_slave_write();
    @(posedge clk_sys_in);
    rq.delete();
    mrq.delete();
    s_tx_data <= 8'h3C;
    s_tx_valid <= 1'b1;
    for (n = 0; n < LIM && mrq.size() == 0; n++) begin
      @(posedge clk_sys_in);
      if (s_tx_ready) s_tx_valid <= 1'b0;
    end
    guard();
    repeat (60) @(posedge clk_sys_in);
    check(mrq[0], 8'h3C);
    check_frame(rq, SLAVE_MSG_LEN, 8'h3C);
  endtask

  // the fifo fills, busy is held and the master stalls until drained
  task automatic sc_fifo_full();
    send(8'h0A, 8'h40);
    s_rx_ready <= 1'b0;
    repeat (600) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    check(s_busy, 1'b1);
    check(link.slave_busy_flag, 1'b1);
    check(txk, 9);
    check(s_rx_valid, 1'b1);
    @(posedge clk_sys_in);
    s_rx_ready <= 1'b1;
    end_send(8'h0A, 8'h40);
  endtask

  task automatic sc_resync();
    @(posedge clk_sys_in);
    wq.delete();
    rq.delete();
    m_resync <= 1'b1;
    @(posedge clk_sys_in);
    m_resync <= 1'b0;
    for (n = 0; n < LIM && !has_byte(rq, REQ_A_ACK); n++) @(posedge clk_sys_in);
    guard();
    // the master flags sync only after the hold of the acknowledge read
    repeat (10) @(posedge clk_sys_in);
    check(has_byte(wq, REQ_A_CODE), 1'b1);
    check(m_synced, 1'b1);
    check(s_synced, 1'b1);
  endtask

  task automatic sc_slave_b();
    sc_sync(ROLE_SLAVE_B);
    check(link.slave_busy_flag, 1'b0);
    send(8'h02, 8'hB0);
    end_send(8'h02, 8'hB0);
    check(last_ctrl & 8'hFE, 8'h00);
    sc_slave_write();
  endtask

  initial begin
    sc_sync(ROLE_SLAVE_A);
    send(8'h03, 8'hA0);
    end_send(8'h03, 8'hA0);
    sc_slave_write();
    sc_fifo_full();
    sc_resync();
    sc_slave_b();
    complete_run();
  end
endmodule
`default_nettype wire
